// ---- src/eofs_supervisor.sv ----
// Purpose: emergency override supervisor with fault sorting and APB registers
// Assumes: fault inputs and requests come from sys_clk logic; terminals are pins
// Notes: ramps use accel_time and decel_time outside this block
// What this block does
// - Override needs selection 2 (or test selection 1) plus function-51 input
// - Count each real override run by one
// - Test option: run, no retries, no count
// - Override frequency beats jog, multistep, keypad
// - Override direction parameter sets rotation
// - Normal ramps; stop when input drops
// - Log ignored faults; hide trip_out, tripped still shows
// - Ignore minor faults during override
// - Retry overvoltage, overcurrent, ground until clear
// - No retry limit; retry delay still applies
// - Diagnostic or arm short stops the drive
//
// The APB slave port and the register offsets are this design's own decisions.
`include "eofs_params.svh"
`default_nettype none
module eofs_supervisor #(
  parameter int MS_CYCLES = `EOFS_MS_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals and fault detectors
  input wire logic [6:0] multi_function_input,
  input wire eofs_pkg::eofs_fault_t faults,
  input wire logic fault_reset_req,
  // Normal drive request
  input wire logic norm_run,
  input wire logic norm_dir,
  input wire logic [6:0] norm_freq,
  // Drive side
  output eofs_pkg::eofs_drive_t drive,
  output logic fault_reset,
  output logic trip_out,
  output logic tripped,
  output logic log_valid,
  output eofs_pkg::eofs_fault_t log_faults,
  output logic irq
);
  // ****************************************
  // Storage
  // ****************************************
  logic [1:0] sel, next_sel;
  logic dir, next_dir;
  logic [6:0] ovr_freq, next_ovr_freq;
  logic [15:0] delay, next_delay;
  logic [7:0] limit, next_limit;
  logic [3:0] irq_stat, next_irq_stat;
  logic [3:0] irq_mask, next_irq_mask;
  logic [7:0] func [7];
  logic [7:0] next_func [7];
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [6:0] term_s1, term_s2;
  eofs_pkg::eofs_state_t state, next_state;
  logic [15:0] run_count, next_run_count;
  logic [7:0] retries, next_retries;
  logic [15:0] ms_left, next_ms_left;
  logic [31:0] tick, next_tick;
  logic ovr_req_q, next_ovr_req_q;
  eofs_pkg::eofs_fault_t faults_q;
  eofs_pkg::eofs_drive_t next_drive;
  logic next_fault_reset, next_trip_out, next_tripped, next_log_valid;
  logic [3:0] ev;
  logic ovr_req, ovr_on, ovr_test, new_fault, any_retry, any_stop, any_minor;
  // Clamp written frequency to the 0..60 range
  function automatic logic [6:0] eofs_clamp(input logic [6:0] f);
    eofs_clamp = (f > `EOFS_FREQ_MAX) ? `EOFS_FREQ_MAX : f;
  endfunction : eofs_clamp
  // Terminal function code window, one aligned word per terminal
  function automatic logic eofs_func_hit(input logic [11:0] a);
    eofs_func_hit = a >= `EOFS_OFF_FUNC0 && a < `EOFS_OFF_FUNC0 + 12'h01C && a[1:0] == 2'h0;
  endfunction : eofs_func_hit
  // ****************************************
  // Terminal synchroniser
  // ****************************************
  // Terminals are pins, so two flops before any decode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      term_s1 <= 7'h00;
      term_s2 <= 7'h00;
    end else begin
      term_s1 <= multi_function_input;
      term_s2 <= term_s1;
    end
  end
  // ****************************************
  // Override request decode
  // ****************************************
  // Any terminal assigned the override function and asserted
  always_comb begin
    ovr_req = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (func[i] == `EOFS_FC_OVERRIDE && term_s2[i]) begin
        ovr_req = 1'b1;
      end
    end
    ovr_on = ovr_req && (sel == `EOFS_SEL_ON || sel == `EOFS_SEL_TEST);
    ovr_test = ovr_req && sel == `EOFS_SEL_TEST;
    any_minor = |faults.minor;
    any_retry = |faults.retry;
    any_stop = |faults.stop;
    new_fault = |(faults & ~faults_q);
  end
  // ****************************************
  // Supervisor next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_run_count = run_count;
    next_retries = retries;
    next_ms_left = ms_left;
    next_tick = tick;
    next_ovr_req_q = ovr_on;
    next_fault_reset = 1'b0;
    next_log_valid = new_fault;
    next_trip_out = 1'b0;
    next_tripped = 1'b0;
    ev = 4'h0;
    // Count only real runs, on entry
    if (ovr_on && !ovr_req_q) begin
      ev[`EOFS_EV_ENTER] = 1'b1;
      if (!ovr_test && run_count != 16'hFFFF) begin
        next_run_count = run_count + 16'h0001;
      end
    end
    // Leaving override restores the normal attempt budget
    if (!ovr_on && ovr_req_q) begin
      next_retries = 8'h00;
    end
    if (ovr_on && new_fault && any_minor && !any_retry && !any_stop) begin
      ev[`EOFS_EV_IGNORE] = 1'b1;
    end
    unique case (state)
      eofs_pkg::ST_RUN: begin
        if (ovr_on) begin
          if (any_stop) begin
            next_state = eofs_pkg::ST_TRIP;
            ev[`EOFS_EV_STOP] = 1'b1;
          end else if (any_retry) begin
            // Test option never restarts by itself
            next_state = ovr_test ? eofs_pkg::ST_TRIP : eofs_pkg::ST_WAIT;
            ev[`EOFS_EV_RETRY] = !ovr_test;
            next_ms_left = delay;
            next_tick = 32'h0;
          end
        end else if (any_stop || any_retry || any_minor) begin
          // Normal handling: retry while the budget lasts
          if (retries < limit) begin
            next_state = eofs_pkg::ST_WAIT;
            next_ms_left = delay;
            next_tick = 32'h0;
          end else begin
            next_state = eofs_pkg::ST_TRIP;
          end
        end
      end
      eofs_pkg::ST_WAIT: begin
        if (ovr_on && any_stop) begin
          next_state = eofs_pkg::ST_TRIP;
          ev[`EOFS_EV_STOP] = 1'b1;
        end else if (ms_left != 16'h0) begin
          if (tick == MS_CYCLES - 1) begin
            next_tick = 32'h0;
            next_ms_left = ms_left - 16'h0001;
          end else begin
            next_tick = tick + 32'h1;
          end
        end else if (ovr_on ? any_retry : (any_stop || any_retry || any_minor)) begin
          // Condition still present: wait another delay
          next_ms_left = delay;
          if (!ovr_on) begin
            next_retries = retries + 8'h01;
            if (retries + 8'h01 >= limit) begin
              next_state = eofs_pkg::ST_TRIP;
            end
          end
        end else begin
          next_fault_reset = 1'b1;
          next_state = eofs_pkg::ST_RUN;
          if (!ovr_on) begin
            next_retries = retries + 8'h01;
          end
        end
      end
      eofs_pkg::ST_TRIP: begin
        // Software or keypad reset clears a latched trip
        if (fault_reset_req) begin
          next_fault_reset = 1'b1;
          next_state = eofs_pkg::ST_RUN;
          next_retries = 8'h00;
        end
      end
      default: next_state = eofs_pkg::ST_RUN;
    endcase
    // Trip relay stays quiet while override runs
    next_tripped = (next_state == eofs_pkg::ST_TRIP);
    next_trip_out = next_tripped && !ovr_on;
  end
  // Drive command mux: override source wins
  always_comb begin
    next_drive.ovr_active = ovr_on;
    next_drive.freq = ovr_on ? ovr_freq : norm_freq;
    next_drive.dir = ovr_on ? dir : norm_dir;
    // Held off the cycle override ends; waiting or tripped ramps down on decel_time
    next_drive.run = (ovr_on || (norm_run && !ovr_req_q)) && next_state == eofs_pkg::ST_RUN;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= eofs_pkg::ST_RUN;
      run_count <= 16'h0000;
      retries <= 8'h00;
      ms_left <= 16'h0000;
      tick <= 32'h0;
      ovr_req_q <= 1'b0;
      faults_q <= '0;
      drive <= '0;
      fault_reset <= 1'b0;
      trip_out <= 1'b0;
      tripped <= 1'b0;
      log_valid <= 1'b0;
      log_faults <= '0;
    end else begin
      state <= next_state;
      run_count <= next_run_count;
      retries <= next_retries;
      ms_left <= next_ms_left;
      tick <= next_tick;
      ovr_req_q <= next_ovr_req_q;
      faults_q <= faults;
      drive <= next_drive;
      fault_reset <= next_fault_reset;
      trip_out <= next_trip_out;
      tripped <= next_tripped;
      log_valid <= next_log_valid;
      log_faults <= faults;
    end
  end
  // ****************************************
  // APB register file
  // ****************************************
  always_comb begin
    logic wr;
    wr = psel && penable && pwrite;
    next_sel = sel;
    next_dir = dir;
    next_ovr_freq = ovr_freq;
    next_delay = delay;
    next_limit = limit;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_func = func;
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    // Answer in the cycle after setup, so pready is registered
    next_pready = psel && !penable;
    if (wr) begin
      unique case (paddr)
        `EOFS_OFF_CTRL: begin
          next_sel = (pwdata[1:0] == 2'h3) ? sel : pwdata[1:0];
          next_dir = pwdata[`EOFS_CTRL_DIR_BIT];
        end
        `EOFS_OFF_FREQ: next_ovr_freq = eofs_clamp(pwdata[6:0]);
        `EOFS_OFF_DELAY: next_delay = pwdata[15:0];
        `EOFS_OFF_LIMIT: next_limit = pwdata[7:0];
        `EOFS_OFF_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[3:0];
        `EOFS_OFF_IRQ_MASK: next_irq_mask = pwdata[3:0];
        default: begin
          if (eofs_func_hit(paddr)) begin
            next_func[paddr[4:2]] = pwdata[7:0];
          end
        end
      endcase
    end
    // Set wins over a same-cycle clear
    next_irq_stat = next_irq_stat | ev;
    if (psel && !penable) begin
      unique case (paddr)
        `EOFS_OFF_CTRL: next_prdata = {29'h0, dir, sel};
        `EOFS_OFF_FREQ: next_prdata = {25'h0, ovr_freq};
        `EOFS_OFF_DELAY: next_prdata = {16'h0, delay};
        `EOFS_OFF_LIMIT: next_prdata = {24'h0, limit};
        `EOFS_OFF_COUNT: next_prdata = {16'h0, run_count};
        `EOFS_OFF_STATUS: next_prdata = {24'h0, retries[3:0], ovr_test, ovr_on, state};
        `EOFS_OFF_IRQ_STAT: next_prdata = {28'h0, irq_stat};
        `EOFS_OFF_IRQ_MASK: next_prdata = {28'h0, irq_mask};
        default: begin
          if (eofs_func_hit(paddr)) begin
            next_prdata = {24'h0, func[paddr[4:2]]};
          end else begin
            next_pslverr = 1'b1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sel <= `EOFS_SEL_OFF;
      dir <= 1'b0;
      ovr_freq <= 7'h00;
      delay <= `EOFS_RST_DELAY;
      limit <= `EOFS_RST_LIMIT;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      for (int i = 0; i < 7; i++) begin
        func[i] <= 8'h00;
      end
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      sel <= next_sel;
      dir <= next_dir;
      ovr_freq <= next_ovr_freq;
      delay <= next_delay;
      limit <= next_limit;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      func <= next_func;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= |(next_irq_stat & next_irq_mask);
    end
  end
endmodule : eofs_supervisor
`default_nettype wire

// ---- src/eofs_params.svh ----
// Purpose: constants of the emergency override fault supervisor
// Assumes: 40 MHz sys_clk, 32-bit APB
// Notes: offsets are byte addresses
`ifndef EOFS_PARAMS_SVH
`define EOFS_PARAMS_SVH
// ****************************************
// Register offsets
// ****************************************
`define EOFS_OFF_CTRL 12'h000
`define EOFS_OFF_FREQ 12'h004
`define EOFS_OFF_DELAY 12'h008
`define EOFS_OFF_LIMIT 12'h00C
`define EOFS_OFF_COUNT 12'h010
`define EOFS_OFF_STATUS 12'h014
`define EOFS_OFF_IRQ_STAT 12'h018
`define EOFS_OFF_IRQ_MASK 12'h01C
`define EOFS_OFF_FUNC0 12'h020
// ****************************************
// Field positions and codes
// ****************************************
`define EOFS_CTRL_DIR_BIT 2
`define EOFS_SEL_OFF 2'h0
`define EOFS_SEL_TEST 2'h1
`define EOFS_SEL_ON 2'h2
`define EOFS_FC_OVERRIDE 8'h33
`define EOFS_FREQ_MAX 7'h3C
`define EOFS_EV_ENTER 0
`define EOFS_EV_IGNORE 1
`define EOFS_EV_RETRY 2
`define EOFS_EV_STOP 3
// ****************************************
// Reset values
// ****************************************
`define EOFS_RST_DELAY 16'h0001
`define EOFS_RST_LIMIT 8'h00
// ****************************************
// Timing
// ****************************************
`define EOFS_CLK_NS 25
`define EOFS_DELAY_UNIT_NS 1000000
`define EOFS_MS_CYCLES (`EOFS_DELAY_UNIT_NS / `EOFS_CLK_NS)
`endif

// ---- src/eofs_pkg.sv ----
// Purpose: types of the emergency override fault supervisor
// Assumes: included constants header
// Notes: fault classes travel together as one struct
`default_nettype none
package eofs_pkg;
  // Supervisor states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_TRIP = 2'b10
  } eofs_state_t;
  // Fault detector inputs, sorted by override class
  typedef struct packed {
    logic [1:0] stop;   // Hardware diagnostic, arm short
    logic [2:0] retry;  // Overvoltage, overcurrent_level_one, ground
    logic [11:0] minor; // safety_stop_input_fault and other minor faults
  } eofs_fault_t;
  // Drive commands
  typedef struct packed {
    logic run;
    logic dir;
    logic ovr_active;
    logic [6:0] freq;
  } eofs_drive_t;
endpackage : eofs_pkg
`default_nettype wire

// ---- verif/eofs_sup_assertions.sv ----
// Purpose: port timing checks for the override supervisor
// Assumes: bound onto eofs_supervisor, one clock domain
// Notes: watches design outputs plus the psel, penable and faults inputs
`default_nettype none
module eofs_sup_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Drive side
  input wire eofs_pkg::eofs_fault_t faults,
  input wire eofs_pkg::eofs_drive_t drive,
  input wire logic fault_reset,
  input wire logic trip_out,
  input wire logic tripped,
  input wire logic log_valid
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bus_answer_a: assert property (psel && !penable |=> pready && !$past(pready))
    else $error("no bus answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ovr_no_trip_a: assert property (drive.ovr_active |-> !trip_out)
    else $error("trip output during override");
  minor_log_a: assert property (drive.ovr_active && faults.minor != 12'h0 &&
    $past(faults.minor) == 12'h0 |=> log_valid) else $error("ignored fault not logged");
  minor_ignore_a: assert property (drive.ovr_active && drive.run && !tripped &&
    faults.stop == 2'h0 && faults.retry == 3'h0 && faults.minor != 12'h0 |=> drive.run)
    else $error("minor fault stopped override");
  retry_hold_a: assert property (drive.ovr_active && drive.run &&
    faults.retry != 3'h0 |=> !drive.run && !fault_reset) else $error("retry fault ignored");
  restart_clear_a: assert property (fault_reset && drive.ovr_active |->
    $past(faults.retry) == 3'h0) else $error("restart while fault present");
  reset_pulse_a: assert property (fault_reset |=> !fault_reset)
    else $error("fault reset longer than one cycle");
  stop_trip_a: assert property (drive.ovr_active && faults.stop != 2'h0 |=>
    tripped && !drive.run && !trip_out) else $error("stop fault did not stop");
  ovr_drop_a: assert property ($fell(drive.ovr_active) |-> !drive.run)
    else $error("still running after override end");
endmodule : eofs_sup_assertions
`default_nettype wire

// ---- verif/eofs_far_side.sv ----
// Purpose: model of terminals and fault detectors
// Assumes: bench requests levels after rising edges
// Notes: levels reach the supervisor one cycle later
`default_nettype none
module eofs_far_side (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Requests from the bench
  input wire logic [6:0] term_req,
  input wire eofs_pkg::eofs_fault_t fault_req,
  // Toward the supervisor
  output logic [6:0] multi_function_input,
  output eofs_pkg::eofs_fault_t faults
);
  // Registered like real detectors, so no level ever changes mid-cycle
  always_ff @(posedge sys_clk) begin
    multi_function_input <= sys_rst ? 7'h00 : term_req;
    faults <= sys_rst ? '0 : fault_req;
  end
endmodule : eofs_far_side
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the override supervisor
// Assumes: MS_CYCLES cut to 4 cycles per ms
// Notes: random values from a fixed seed
`include "eofs_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bench state
  // ****************************************
  localparam int MSC = 4;
  localparam int DLY = 2;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, fault_reset_req, err;
  logic norm_run, norm_dir, fault_reset, trip_out, tripped, log_valid, irq, nd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] term_req, multi_function_input, norm_freq, ef, nf;
  logic [11:0] mv;
  eofs_pkg::eofs_fault_t fault_req, faults, log_faults;
  eofs_pkg::eofs_drive_t drive;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h12b6;
  int n, p;
  eofs_supervisor #(.MS_CYCLES(MSC)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .multi_function_input(multi_function_input),
    .faults(faults), .fault_reset_req(fault_reset_req), .norm_run(norm_run),
    .norm_dir(norm_dir), .norm_freq(norm_freq), .drive(drive), .fault_reset(fault_reset),
    .trip_out(trip_out), .tripped(tripped), .log_valid(log_valid),
    .log_faults(log_faults), .irq(irq));
  eofs_far_side far (.sys_clk(sys_clk), .sys_rst(sys_rst), .term_req(term_req),
    .fault_req(fault_req), .multi_function_input(multi_function_input), .faults(faults));
  // Clock, 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Ready and read data are taken at the rising edge that sees pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  function logic sig(input int k);
    case (k)
      0: return drive.ovr_active;
      1: return fault_reset;
      2: return tripped;
      default: return drive.run;
    endcase
  endfunction : sig
  // Bounded wait for a design flag, then compare it
  task wt(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk(sig(k), v);
  endtask : wt
  task setf(input logic [16:0] v);
    @(posedge sys_clk);
    fault_req <= v;
  endtask : setf
  task clr_trip;
    setf(17'h0);
    @(posedge sys_clk);
    fault_reset_req <= 1'b1;
    @(posedge sys_clk);
    fault_reset_req <= 1'b0;
    wt(2, 1'b0);
  endtask : clr_trip
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    results();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {psel, penable, pwrite, fault_reset_req, norm_run, norm_dir} = 6'h0;
    {paddr, pwdata, term_req, norm_freq, fault_req} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(`EOFS_OFF_DELAY, 32'h1);
    rchk(`EOFS_OFF_COUNT, 32'h0);
    rchk(12'h100, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `EOFS_OFF_CTRL, 32'h7);
    rchk(`EOFS_OFF_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) begin
      ef = (i == 0) ? 7'h3C : (i == 1) ? 7'h3D : 7'($random(seed));
      apb(1'b1, `EOFS_OFF_FREQ, {25'h0, ef});
      rchk(`EOFS_OFF_FREQ, {25'h0, (ef > `EOFS_FREQ_MAX) ? `EOFS_FREQ_MAX : ef});
    end
    ef = (ef > `EOFS_FREQ_MAX) ? `EOFS_FREQ_MAX : ef;
    nf = 7'($unsigned($random(seed)) % 61);
    nd = 1'($random(seed));
    {norm_run, norm_dir, norm_freq} <= {1'b1, nd, nf};
    wt(3, 1'b1);
    chk({22'h0, drive}, {22'h0, 1'b1, nd, 1'b0, nf});
    apb(1'b1, `EOFS_OFF_FUNC0 + 12'h00C, {24'h0, `EOFS_FC_OVERRIDE});
    apb(1'b1, `EOFS_OFF_IRQ_MASK, 32'hF);
    term_req <= 7'h08;
    repeat (8) @(negedge sys_clk);
    chk(drive.ovr_active, 1'b0);
    apb(1'b1, `EOFS_OFF_CTRL, 32'h6);
    wt(0, 1'b1);
    chk({22'h0, drive}, {22'h0, 3'b111, ef});
    rchk(`EOFS_OFF_COUNT, 32'h1);
    chk(irq, 1'b1);
    mv = 12'($random(seed)) | 12'h001;
    setf({5'h0, mv});
    repeat (5) @(negedge sys_clk);
    chk({drive.run, trip_out, log_faults.minor}, {2'b10, mv});
    setf(17'h0);
    apb(1'b1, `EOFS_OFF_DELAY, DLY);
    setf(17'h01000);
    setf(17'h0);
    n = 0;
    while (fault_reset !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= DLY * MSC && n <= DLY * MSC + 3, 1'b1);
    setf(17'h02000);
    p = 0;
    repeat (4 * DLY * MSC) begin
      @(negedge sys_clk);
      p += fault_reset;
    end
    chk(p, 0);
    apb(1'b0, `EOFS_OFF_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h5);
    setf(17'h0);
    wt(1, 1'b1);
    setf(17'h08000);
    wt(2, 1'b1);
    chk({drive.run, trip_out}, 2'b00);
    clr_trip();
    @(posedge sys_clk);
    norm_run <= 1'b0;
    term_req <= 7'h00;
    wt(0, 1'b0);
    chk(drive.run, 1'b0);
    apb(1'b1, `EOFS_OFF_CTRL, 32'h1);
    term_req <= 7'h08;
    wt(0, 1'b1);
    setf(17'h01000);
    wt(2, 1'b1);
    rchk(`EOFS_OFF_COUNT, 32'h1);
    clr_trip();
    term_req <= 7'h00;
    apb(1'b1, `EOFS_OFF_CTRL, 32'h0);
    wt(0, 1'b0);
    setf(17'h00004);
    wt(2, 1'b1);
    chk(trip_out, 1'b1);
    clr_trip();
    rchk(`EOFS_OFF_IRQ_STAT, 32'hF);
    apb(1'b1, `EOFS_OFF_IRQ_MASK, 32'h0);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    apb(1'b1, `EOFS_OFF_IRQ_MASK, 32'hF);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    apb(1'b1, `EOFS_OFF_IRQ_STAT, 32'hF);
    rchk(`EOFS_OFF_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    results();
  end
endmodule : tb_top
bind eofs_supervisor eofs_sup_assertions chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pready(pready), .faults(faults), .drive(drive),
  .fault_reset(fault_reset), .trip_out(trip_out), .tripped(tripped), .log_valid(log_valid));
`default_nettype wire
